// File: rtl/pos_encoder_end.sv
// Function
// - clock idles high, shift on rise
// - host keeps clock 100 kHz to 5 MHz
// - frame is six bytes, 48 bits
// - bits 47 to 33 always zero
// - bit 32 set at factory zero
// - bit 31 flags valid position
// - bit 30 flags frame-triggered measurement
// - bits 29 to 8 angle, msbs zeroed
// - bit 7 flags already sent value
// - crc7 poly 5b, init zero, msb first
// - crc covers bits 32 down to 7
// - host checks sync and repeat flags; pos_host_end checks only the crc
// - frame start triggers measurement unless busy
// - auto measurement after timeout
// - idle gap resets frame position
//
// module: encoder end, clocked by the link oscillator
// assumes: link_clk_in free running; sclk and sensor inputs asynchronous
`timescale 1ns/1ps
module pos_encoder_end #(
  parameter int RESOLUTION  = 22,
  parameter int IDLE_CYC    = pos_frame_pkg::IDLE_RESET_CYC,
  parameter int TIMEOUT_CYC = pos_frame_pkg::MEAS_TIMEOUT_CYC,
  parameter int MEAS_CYC    = pos_frame_pkg::MEAS_TIME_CYC
) (
  input  wire logic        link_clk_in,
  input  wire logic        nrst_in,
  pos_link_if.encoder      link,
  input  wire logic [21:0] angle_in,
  input  wire logic        angle_ok_in,
  input  wire logic        zero_factory_in,
  output logic             measure_busy_out,
  output logic             frame_active_out
);
  typedef enum logic [1:0] {M_IDLE, M_RUN} meas_e;
  meas_e            meas_state;
  logic [2:0]       sclk_s;
  logic [1:0]       ang_ok_s;
  logic [1:0]       zero_s;
  logic [21:0]      ang_m;
  logic [21:0]      ang_s;
  logic [15:0]      idle_cnt;
  logic             synced;
  logic [5:0]       bit_cnt;
  logic [47:0]      shreg;
  logic [15:0]      to_cnt;
  logic [15:0]      meas_cnt;
  logic             meas_by_frame;
  logic [21:0]      res_angle;
  logic             res_valid;
  logic             res_sync;
  logic             res_sent;
  logic             res_zero;
  logic             fall;
  logic             rise;
  logic             frame_start;
  logic             trig_auto;
  logic [21:0]      angle_mask;
  logic [31:0]      crc_word;
  logic [47:0]      next_frame;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_s   <= 3'h7;
      ang_ok_s <= 2'h0;
      zero_s   <= 2'h0;
      ang_m    <= '0;
      ang_s    <= '0;
    end else begin
      sclk_s   <= {sclk_s[1:0], link.sclk};
      ang_ok_s <= {ang_ok_s[0], angle_ok_in};
      zero_s   <= {zero_s[0], zero_factory_in};
      ang_m    <= angle_in;
      ang_s    <= ang_m;
    end
  end

  assign fall = sclk_s[2] && !sclk_s[1];
  assign rise = !sclk_s[2] && sclk_s[1];

  // ---------------------------------------------------------------
  // idle gap detection
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_cnt <= '0;
    end else if (fall || rise || !sclk_s[1]) begin
      idle_cnt <= '0;
    end else if (idle_cnt != 16'(IDLE_CYC)) begin
      idle_cnt <= idle_cnt + 16'h0001;
    end
  end

  assign frame_start = fall && (bit_cnt == 6'h00 || !synced);

  // ---------------------------------------------------------------
  // frame assembly
  // ---------------------------------------------------------------
  assign angle_mask = 22'((64'h1 << RESOLUTION) - 64'h1);
  always_comb begin
    next_frame = '0;
    next_frame[pos_frame_pkg::ZERO_REF_BIT] = res_zero;
    next_frame[pos_frame_pkg::VALID_BIT]    = res_valid;
    next_frame[pos_frame_pkg::SYNC_BIT]     = res_sync;
    next_frame[pos_frame_pkg::ANGLE_HI:pos_frame_pkg::ANGLE_LO] =
      res_angle & angle_mask;
    next_frame[pos_frame_pkg::REPEAT_BIT]   = res_sent;
    crc_word = {6'h00, next_frame[32:7]};
    next_frame[pos_frame_pkg::CRC_BITS-1:0] =
      pos_frame_pkg::crc7(crc_word);
  end

  // ---------------------------------------------------------------
  // shifter, mode 2 timing
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      synced    <= 1'b0;
      bit_cnt   <= '0;
      shreg     <= '0;
      link.miso <= 1'b0;
    end else begin
      if (frame_start) begin
        synced    <= 1'b1;
        shreg     <= {next_frame[46:0], 1'b0};
        link.miso <= next_frame[47];
        bit_cnt   <= 6'h01;
      end else if (idle_cnt == 16'(IDLE_CYC) - 16'h0001) begin
        // line rests at bit 47, always zero, before the first fall
        synced    <= 1'b0;
        bit_cnt   <= '0;
        link.miso <= 1'b0;
      end else if (rise && bit_cnt != 6'h00) begin
        link.miso <= shreg[47];
        shreg     <= {shreg[46:0], 1'b0};
        if (bit_cnt == 6'(pos_frame_pkg::FRAME_BITS)) begin
          bit_cnt <= '0;
        end
      end else if (fall && bit_cnt != 6'h00) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // measurement engine
  // ---------------------------------------------------------------
  assign trig_auto = to_cnt == 16'(TIMEOUT_CYC);

  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meas_state    <= M_IDLE;
      to_cnt        <= '0;
      meas_cnt      <= '0;
      meas_by_frame <= 1'b0;
      res_angle     <= '0;
      res_valid     <= 1'b0;
      res_sync      <= 1'b0;
      res_sent      <= 1'b0;
      res_zero      <= 1'b0;
    end else begin
      if (frame_start) begin
        res_sent <= 1'b1;
      end
      unique case (meas_state)
        M_IDLE: begin
          to_cnt <= to_cnt + 16'h0001;
          if (frame_start || trig_auto) begin
            meas_state    <= M_RUN;
            meas_by_frame <= frame_start;
            meas_cnt      <= '0;
            to_cnt        <= '0;
          end
        end
        M_RUN: begin
          to_cnt   <= to_cnt + 16'h0001;
          meas_cnt <= meas_cnt + 16'h0001;
          if (meas_cnt == 16'(MEAS_CYC)) begin
            meas_state <= M_IDLE;
            res_angle  <= ang_s;
            res_valid  <= ang_ok_s[1];
            res_sync   <= meas_by_frame;
            res_zero   <= zero_s[1];
            res_sent   <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      measure_busy_out <= 1'b0;
      frame_active_out <= 1'b0;
    end else begin
      measure_busy_out <= meas_state == M_RUN;
      frame_active_out <= bit_cnt != 6'h00;
    end
  end
endmodule

// File: rtl/pos_frame_pkg.sv
// package: frame layout, crc and timing constants for the position link
// assumes: shared by the encoder end and the host end
package pos_frame_pkg;
  localparam int FRAME_BITS      = 48;
  localparam int BYTE_BITS       = 8;
  localparam int FRAME_BYTES     = 6;
  localparam int ZERO_REF_BIT    = 32;
  localparam int VALID_BIT       = 31;
  localparam int SYNC_BIT        = 30;
  localparam int ANGLE_HI        = 29;
  localparam int ANGLE_LO        = 8;
  localparam int ANGLE_BITS      = 22;
  localparam int REPEAT_BIT      = 7;
  localparam int CRC_BITS        = 7;
  localparam logic [6:0] CRC_POLY = 7'h5b;
  localparam logic [6:0] CRC_INIT = 7'h00;
  // link side times in ns; link clock period 48 ns
  localparam int LINK_PERIOD_NS  = 48;
  localparam int IDLE_RESET_NS   = 10000;
  localparam int MEAS_TIMEOUT_NS = 140000;
  localparam int MEAS_TIME_NS    = 92000;
  localparam int IDLE_RESET_CYC  = (IDLE_RESET_NS + LINK_PERIOD_NS - 1)
                                   / LINK_PERIOD_NS;
  localparam int MEAS_TIMEOUT_CYC = MEAS_TIMEOUT_NS / LINK_PERIOD_NS;
  localparam int MEAS_TIME_CYC   = MEAS_TIME_NS / LINK_PERIOD_NS;
  // host side, 25 MHz
  localparam int SYS_PERIOD_NS   = 40;
  localparam int SCLK_DIV        = 10;
  localparam int HOST_GAP_NS     = 2000;
  localparam int HOST_GAP_CYC    = HOST_GAP_NS / SYS_PERIOD_NS;

  // crc over 32-bit word, msb first, no reflection, no final xor
  function automatic logic [6:0] crc7(input logic [31:0] word);
    logic [6:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      fb = c[6] ^ word[i];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction
endpackage

// File: rtl/pos_link_if.sv
// interface: serial link between host master and encoder slave
// assumes: host drives clock and select-free framing; encoder drives data
`timescale 1ns/1ps
interface pos_link_if;
  logic sclk;
  logic miso;
  modport host (output sclk, input miso);
  modport encoder (input sclk, output miso);
endinterface

// File: rtl/sync_fifo.sv
// module: single clock fifo, width and depth parameters
// assumes: one clock, power of two depth
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready_out = (wp - rp) != (AW + 1)'(DEPTH);
  assign rd_valid_out = wp != rp;
  assign rd_data_out  = mem[rp[AW-1:0]];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  always_ff @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wp[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (do_wr) begin
        wp <= wp + 1'b1;
      end
      if (do_rd) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule

// File: rtl/pos_host_end.sv
// module: host master, reads frames and queues them through a fifo
// assumes: sys_clk_in 25 MHz; miso asynchronous to it
`timescale 1ns/1ps
module pos_host_end #(
  parameter int DIV   = pos_frame_pkg::SCLK_DIV,
  parameter int GAP   = pos_frame_pkg::HOST_GAP_CYC,
  parameter int DEPTH = 16
) (
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  pos_link_if.host         link,
  input  wire logic        start_in,
  output logic [47:0]      frame_out,
  output logic             frame_valid_out,
  input  wire logic        frame_ready_in,
  output logic             crc_ok_out,
  output logic             busy_out
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} host_e;
  host_e       state;
  logic [1:0]  miso_s;
  logic [7:0]  div_cnt;
  logic [5:0]  bit_cnt;
  logic [47:0] shreg;
  logic [7:0]  gap_cnt;
  logic        push;
  logic        fifo_ready;
  logic [47:0] fifo_data;
  logic        fifo_valid;

  // ---------------------------------------------------------------
  // serial clock generation and sampling
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_s <= 2'h0;
    end else begin
      miso_s <= {miso_s[0], link.miso};
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state     <= H_IDLE;
      link.sclk <= 1'b1;
      div_cnt   <= '0;
      bit_cnt   <= '0;
      shreg     <= '0;
      gap_cnt   <= '0;
      push      <= 1'b0;
    end else begin
      push <= 1'b0;
      unique case (state)
        H_IDLE: begin
          link.sclk <= 1'b1;
          if (start_in && fifo_ready) begin
            // first fall samples bit 47 already resting on the line
            state     <= H_LOW;
            link.sclk <= 1'b0;
            div_cnt   <= '0;
            shreg     <= {shreg[46:0], miso_s[1]};
            bit_cnt   <= 6'h01;
          end
        end
        H_LOW: begin
          div_cnt <= div_cnt + 8'h01;
          if (div_cnt == 8'(DIV - 1)) begin
            div_cnt   <= '0;
            link.sclk <= 1'b1;
            state     <= H_HIGH;
          end
        end
        H_HIGH: begin
          div_cnt <= div_cnt + 8'h01;
          if (div_cnt == 8'(DIV - 1)) begin
            div_cnt <= '0;
            if (bit_cnt == 6'(pos_frame_pkg::FRAME_BITS)) begin
              state   <= H_GAP;
              push    <= 1'b1;
              gap_cnt <= '0;
            end else begin
              shreg     <= {shreg[46:0], miso_s[1]};
              bit_cnt   <= bit_cnt + 6'h01;
              link.sclk <= 1'b0;
              state     <= H_LOW;
            end
          end
        end
        H_GAP: begin
          gap_cnt <= gap_cnt + 8'h01;
          if (gap_cnt == 8'(GAP)) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame queue
  // ---------------------------------------------------------------
  sync_fifo #(
    .WIDTH (48),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .nrst_in      (nrst_in),
    .wr_data_in   (shreg),
    .wr_valid_in  (push),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (frame_ready_in && !frame_valid_out)
  );

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_out       <= '0;
      frame_valid_out <= 1'b0;
      crc_ok_out      <= 1'b0;
      busy_out        <= 1'b0;
    end else begin
      // busy from the edge that lowers the clock
      busy_out <= (state != H_IDLE) || (start_in && fifo_ready);
      if (frame_valid_out && frame_ready_in) begin
        frame_valid_out <= 1'b0;
      end else if (!frame_valid_out && fifo_valid && frame_ready_in) begin
        frame_valid_out <= 1'b1;
        frame_out       <= fifo_data;
        crc_ok_out      <= pos_frame_pkg::crc7({6'h00, fifo_data[32:7]})
                           == fifo_data[6:0];
      end
    end
  end
endmodule

// File: tb/pos_link_properties.sv
// checker: host frame, wire and measurement timing properties
// assumes: instanced in tb_top beside the link interface
`timescale 1ns/1ps
module pos_link_properties #(
  parameter int MEAS_CYC    = 1916,
  parameter int TIMEOUT_CYC = 2916
) (
  input  wire logic        sys_clk_in,
  input  wire logic        link_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        sclk,
  input  wire logic        miso,
  input  wire logic        busy_out,
  input  wire logic [47:0] frame_out,
  input  wire logic        frame_valid_out,
  input  wire logic        frame_ready_in,
  input  wire logic        crc_ok_out,
  input  wire logic        measure_busy_out,
  input  wire logic        frame_active_out
);
  logic        sclk_q;
  logic [5:0]  fall_cnt;
  logic        mbusy_q;
  logic [15:0] meas_cnt;
  logic [15:0] trig_cnt;
  // ----
  // helper counters
  // ----
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_q   <= 1'b1;
      fall_cnt <= 6'h00;
    end else begin
      sclk_q   <= sclk;
      fall_cnt <= !busy_out ? 6'h00 : fall_cnt + {5'h00, sclk_q && !sclk};
    end
  end
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mbusy_q  <= 1'b0;
      meas_cnt <= 16'h0000;
      trig_cnt <= 16'h0000;
    end else begin
      mbusy_q  <= measure_busy_out;
      meas_cnt <= measure_busy_out ? meas_cnt + 16'h0001 : 16'h0000;
      trig_cnt <= (measure_busy_out && !mbusy_q) ? 16'h0000
                                                 : trig_cnt + 16'h0001;
    end
  end
  // ----
  // properties
  // ----
  sequence low_phase_s;
    (!sclk)[*8] ##1 (!sclk)[*2] ##1 sclk;
  endsequence
  pad_zero_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) frame_valid_out |-> frame_out[47:33] == 15'h0000)
    else $error("pad bits set");
  crc_good_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) frame_valid_out |-> crc_ok_out)
    else $error("bad check code");
  idle_high_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) !busy_out |-> sclk)
    else $error("clock not idle high");
  low_half_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) $fell(sclk) |-> low_phase_s)
    else $error("low half length wrong");
  high_half_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) $rose(sclk) && busy_out |-> sclk[*8])
    else $error("high half too short");
  frame_hold_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) frame_valid_out && !frame_ready_in
    |=> frame_valid_out && $stable(frame_out))
    else $error("frame dropped while stalled");
  wire_pad_a: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) !sclk && !$past(sclk) && fall_cnt >= 6'h02
    && fall_cnt <= 6'h0e |-> !miso)
    else $error("leading wire bits not zero");
  trig_frame_a: assert property (@(posedge link_clk_in)
    disable iff (!nrst_in)
    $rose(frame_active_out) |-> ##[0:3] measure_busy_out)
    else $error("frame start did not trigger");
  meas_len_a: assert property (@(posedge link_clk_in)
    disable iff (!nrst_in) $fell(measure_busy_out)
    |-> meas_cnt >= MEAS_CYC - 2 && meas_cnt <= MEAS_CYC + 2)
    else $error("measurement length wrong");
  auto_trig_a: assert property (@(posedge link_clk_in)
    disable iff (!nrst_in) trig_cnt <= TIMEOUT_CYC + 8)
    else $error("no automatic measurement");
endmodule

// File: tb/tb_top.sv
// bench: both link ends joined, frames scored against a queue
// assumes: default measure and timeout counts, 20 bit resolution
`timescale 1ns/1ps
module tb_top;
  localparam int RES = 20;
  localparam logic [47:0] MF = 48'hffff_ffff_ffff;
  localparam logic [47:0] MV = 48'hffff_c000_0080;
  localparam logic [47:0] MP = 48'hfffe_0000_0000;
  logic        sys_clk_in      = 1'b0;
  logic        link_clk_in     = 1'b0;
  logic        nrst_in         = 1'b0;
  logic        start_in        = 1'b0;
  logic        frame_ready_in  = 1'b0;
  logic        hold            = 1'b0;
  logic [21:0] angle_in        = 22'h000000;
  logic        angle_ok_in     = 1'b1;
  logic        zero_factory_in = 1'b1;
  logic [47:0] frame_out;
  logic        frame_valid_out;
  logic        crc_ok_out;
  logic        busy_out;
  logic        measure_busy_out;
  logic        frame_active_out;
  logic [31:0] seed            = 32'h58a45f89;
  logic [96:0] q[$];
  logic [96:0] n;
  int          n_errors        = 0;
  int          n_compared      = 0;
  int          cyc             = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  always #24 link_clk_in = ~link_clk_in;
  pos_link_if link_bus ();
  pos_encoder_end #(.RESOLUTION(RES)) u_pos_encoder_end (
    .link_clk_in(link_clk_in), .nrst_in(nrst_in), .link(link_bus),
    .angle_in(angle_in), .angle_ok_in(angle_ok_in),
    .zero_factory_in(zero_factory_in), .measure_busy_out(measure_busy_out),
    .frame_active_out(frame_active_out));
  pos_host_end u_pos_host_end (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(link_bus),
    .start_in(start_in), .frame_out(frame_out),
    .frame_valid_out(frame_valid_out), .frame_ready_in(frame_ready_in),
    .crc_ok_out(crc_ok_out), .busy_out(busy_out));
  pos_link_properties #(.MEAS_CYC(pos_frame_pkg::MEAS_TIME_CYC),
    .TIMEOUT_CYC(pos_frame_pkg::MEAS_TIMEOUT_CYC)) u_props (
    .sys_clk_in(sys_clk_in), .link_clk_in(link_clk_in), .nrst_in(nrst_in),
    .sclk(link_bus.sclk), .miso(link_bus.miso), .busy_out(busy_out),
    .frame_out(frame_out), .frame_valid_out(frame_valid_out),
    .frame_ready_in(frame_ready_in), .crc_ok_out(crc_ok_out),
    .measure_busy_out(measure_busy_out),
    .frame_active_out(frame_active_out));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [47:0] mk(input logic zf, ok, sy,
                                    input logic [21:0] a, input logic rp);
    logic [47:0] f;
    logic [6:0]  c;
    f = {15'h0000, zf, ok, sy, a & ((22'h000001 << RES) - 22'h000001),
         rp, 7'h00};
    c = 7'h00;
    for (int i = 32; i >= 7; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ f[i]) ? 7'h5b : 7'h00);
    f[6:0] = c;
    return f;
  endfunction
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask
  // one frame; expectation noted before the request
  task automatic frame(input logic c, input logic [47:0] m, e);
    int k;
    k = 0;
    q.push_back({c, m, e});
    start_in <= 1'b1;
    @(posedge sys_clk_in);
    start_in <= 1'b0;
    while (busy_out !== 1'b1 && k < 20) begin
      @(posedge sys_clk_in);
      k++;
    end
    while (busy_out !== 1'b0 && k < 3000) begin
      @(posedge sys_clk_in);
      k++;
    end
    check(k < 3000, "frame stuck");
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (q.size() != 0 && k < 4000) begin
      @(posedge sys_clk_in);
      k++;
    end
    check(q.size() == 0, "frames missing");
  endtask
  // ----
  // monitor, ready and watchdog
  // ----
  always @(posedge sys_clk_in) begin
    frame_ready_in <= !hold && rnd() > 32'h7fffffff;
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      test_done();
    end
    if (frame_valid_out === 1'b1 && frame_ready_in === 1'b1) begin
      n = q.size() != 0 ? q.pop_front() : {1'b1, MF, 48'h0};
      check((frame_out & n[95:48]) === (n[47:0] & n[95:48]),
            "frame");
      if (n[96])
        check(crc_ok_out === 1'b1, "crc flag");
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    logic [21:0] a1;
    logic [21:0] a3;
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    a1 = 22'(rnd());
    a3 = 22'(rnd());
    angle_in <= a1;
    frame(1'b0, 48'h0, 48'h0);
    idle(1500);
    angle_in <= 22'(rnd());
    frame(1'b1, MF, mk(1'b1, 1'b1, 1'b1, a1, 1'b0));
    idle(750);
    frame(1'b1, MF, mk(1'b1, 1'b1, 1'b1, a1, 1'b1));
    angle_in <= a3;
    zero_factory_in <= 1'b0;
    idle(3500);
    frame(1'b1, MF, mk(1'b0, 1'b1, 1'b0, a3, 1'b0));
    angle_ok_in <= 1'b0;
    idle(1500);
    frame(1'b1, MV, mk(1'b0, 1'b0, 1'b1, a3, 1'b0));
    drain();
    $display("test pipeline done");
    hold <= 1'b1;
    for (int i = 0; i < 16; i++)
      frame(1'b1, MP, 48'h0);
    start_in <= 1'b1;
    @(posedge sys_clk_in);
    start_in <= 1'b0;
    idle(10);
    check(busy_out === 1'b0, "start taken while full");
    $display("test fill done");
    hold <= 1'b0;
    drain();
    idle(5);
    check(frame_valid_out === 1'b0, "buffer not empty");
    $display("test drain done");
    test_done();
  end
endmodule
